/* File: design/tdp_timer_pwm.v */
// Eight bit period timer with prescaler driving a master and a phase shifted slave pulse
// Behaviour
// - Counter advances by one on each prescaler output pulse from the system clock.
// - Prescale select 00,01,10,11 divides by 1,4,8,16.
// - Counter counts up from zero, returns to zero on increment after period match.
// - Counter equal to period sets the match flag while run is set and not in sleep.
// - Reset sets counter to zero and period to all ones.
// - Counter and period are fully readable and writable anytime.
// - Run bit at control bit 2 enables counting; cleared halts it.
// - Prescale counter cleared by counter write, control write, and reset.
// - Control write leaves the counter value unchanged.
// - Pulse period is period plus one times prescaled clock, shared by both.
// - Both channels share frequency; phase and duty programmed independently.
// - Rollover clears counter and copies pending duty, end, phase to active.
// - Pending master duty writable anytime; active changes only at rollover.
// - Master high time equals duty value prescaled clock periods.
// - Master duty percent equals duty over period plus one times 100.
// - Slave delayed from master by phase value prescaled periods.
// - Phase degrees equal phase over period plus one times 360.
// - Duty value is only a ceiling; no cycle by cycle modulation here.
// - Slave duty is end minus phase, wrapping modulo period plus one when negative.
// - In sleep the timer holds and pulse state holds; resume on wake.
//
// The strobed register port and the address map were decided locally.
`include "tdp_consts.vh"
module tdp_timer_pwm #(
  parameter AW = `TDP_ADDR_W
) (
  input wire mclk,
  input wire rstn,
  input wire sleep,
  input wire [AW-1:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  output reg [7:0] rdata,
  output reg master_pulse,
  output reg slave_pulse,
  output reg match_flag
);
  reg [7:0] timer_count_reg;
  reg [7:0] period_value_reg;
  reg [2:0] timer_control_reg;
  reg [3:0] ps_count_reg;
  reg [7:0] master_duty_pending_reg;
  reg [7:0] slave_end_pending_reg;
  reg [7:0] slave_phase_pending_reg;
  reg [7:0] master_duty_active_reg;
  reg [7:0] slave_end_active_reg;
  reg [7:0] slave_phase_active_reg;
  reg [3:0] ps_limit;
  reg [7:0] rdata_next;
  wire run = timer_control_reg[`TDP_RUN_BIT];
  wire [1:0] ps_sel = timer_control_reg[`TDP_PS_MSB:`TDP_PS_LSB];
  wire wr_count = wr && (addr == `TDP_A_COUNT);
  wire wr_ctrl = wr && (addr == `TDP_A_CTRL);
  wire wr_flag = wr && (addr == `TDP_A_FLAGS);
  wire match = (timer_count_reg == period_value_reg);
  // Sleep freezes everything that moves, so state resumes as it was
  wire tick = run && !sleep && (ps_count_reg == ps_limit);
  wire rollover = tick && match;
  wire [7:0] count_next = rollover ? `TDP_ZERO8 : timer_count_reg + 8'h01;

  always @* begin
    case (ps_sel)
      2'b00: ps_limit = `TDP_PS_DIV1;
      2'b01: ps_limit = `TDP_PS_DIV4;
      2'b10: ps_limit = `TDP_PS_DIV8;
      default: ps_limit = `TDP_PS_DIV16;
    endcase
  end

  always @(posedge mclk) begin
    if (!rstn) begin
      ps_count_reg <= `TDP_PS_ZERO;
    end else if (wr_count || wr_ctrl) begin
      ps_count_reg <= `TDP_PS_ZERO;
    end else if (run && !sleep) begin
      ps_count_reg <= (ps_count_reg == ps_limit) ? `TDP_PS_ZERO : ps_count_reg + `TDP_PS_ONE;
    end
  end

  always @(posedge mclk) begin
    if (!rstn) begin
      timer_count_reg <= `TDP_COUNT_RST;
      period_value_reg <= `TDP_PERIOD_RST;
      timer_control_reg <= `TDP_CTRL_RST;
      master_duty_pending_reg <= `TDP_ZERO8;
      slave_end_pending_reg <= `TDP_ZERO8;
      slave_phase_pending_reg <= `TDP_ZERO8;
    end else begin
      // Software write wins over the increment in the same cycle
      if (wr_count) begin
        timer_count_reg <= wdata;
      end else if (tick) begin
        timer_count_reg <= count_next;
      end
      if (wr && addr == `TDP_A_PERIOD) begin
        period_value_reg <= wdata;
      end
      if (wr_ctrl) begin
        timer_control_reg <= wdata[`TDP_RUN_BIT:0];
      end
      if (wr && addr == `TDP_A_MDUTY) begin
        master_duty_pending_reg <= wdata;
      end
      if (wr && addr == `TDP_A_SEND) begin
        slave_end_pending_reg <= wdata;
      end
      if (wr && addr == `TDP_A_SPHASE) begin
        slave_phase_pending_reg <= wdata;
      end
    end
  end

  always @(posedge mclk) begin
    if (!rstn) begin
      master_duty_active_reg <= `TDP_ZERO8;
      slave_end_active_reg <= `TDP_ZERO8;
      slave_phase_active_reg <= `TDP_ZERO8;
    end else if (rollover) begin
      master_duty_active_reg <= master_duty_pending_reg;
      slave_end_active_reg <= slave_end_pending_reg;
      slave_phase_active_reg <= slave_phase_pending_reg;
    end
  end

  // Pulses are set and reset by compares on the value the counter takes next,
  // so edges line up with the count change; set wins when both compares hit.
  always @(posedge mclk) begin
    if (!rstn) begin
      master_pulse <= 1'b0;
      slave_pulse <= 1'b0;
    end else if (tick) begin
      if (rollover) begin
        master_pulse <= 1'b1;
      end else if (count_next == master_duty_active_reg) begin
        master_pulse <= 1'b0;
      end
      // End below phase wraps through the rollover, giving modulo duty
      if (count_next == slave_phase_active_reg) begin
        slave_pulse <= 1'b1;
      end else if (count_next == slave_end_active_reg) begin
        slave_pulse <= 1'b0;
      end
    end
  end

  // Match raises the flag; set wins over a software clear in the same cycle
  always @(posedge mclk) begin
    if (!rstn) begin
      match_flag <= 1'b0;
    end else if (match && run && !sleep) begin
      match_flag <= 1'b1;
    end else if (wr_flag) begin
      match_flag <= wdata[`TDP_FLAG_BIT];
    end
  end

  always @* begin
    case (addr)
      `TDP_A_COUNT: rdata_next = timer_count_reg;
      `TDP_A_PERIOD: rdata_next = period_value_reg;
      `TDP_A_CTRL: rdata_next = {5'h00, timer_control_reg};
      `TDP_A_FLAGS: rdata_next = {7'h00, match_flag};
      `TDP_A_MDUTY: rdata_next = master_duty_pending_reg;
      `TDP_A_SEND: rdata_next = slave_end_pending_reg;
      `TDP_A_SPHASE: rdata_next = slave_phase_pending_reg;
      `TDP_A_MDUTY_ACT: rdata_next = master_duty_active_reg;
      `TDP_A_SEND_ACT: rdata_next = slave_end_active_reg;
      `TDP_A_SPHASE_ACT: rdata_next = slave_phase_active_reg;
      `TDP_A_STATUS: rdata_next = {6'h00, slave_pulse, master_pulse};
      default: rdata_next = `TDP_ZERO8;
    endcase
  end

  always @(posedge mclk) begin
    if (!rstn) begin
      rdata <= `TDP_ZERO8;
    end else if (rd) begin
      rdata <= rdata_next;
    end else begin
      rdata <= `TDP_ZERO8;
    end
  end
endmodule // tdp_timer_pwm

/* File: inc/tdp_consts.vh */
// Constants for the timer based dual pulse generator
`ifndef TDP_CONSTS_VH
`define TDP_CONSTS_VH
`define TDP_ADDR_W 4
`define TDP_A_COUNT 4'h0
`define TDP_A_PERIOD 4'h1
`define TDP_A_CTRL 4'h2
`define TDP_A_FLAGS 4'h3
`define TDP_A_MDUTY 4'h4
`define TDP_A_SEND 4'h5
`define TDP_A_SPHASE 4'h6
`define TDP_A_MDUTY_ACT 4'h7
`define TDP_A_SEND_ACT 4'h8
`define TDP_A_SPHASE_ACT 4'h9
`define TDP_A_STATUS 4'ha
`define TDP_RUN_BIT 2
`define TDP_PS_LSB 0
`define TDP_PS_MSB 1
`define TDP_FLAG_BIT 0
`define TDP_COUNT_RST 8'h00
`define TDP_PERIOD_RST 8'hff
`define TDP_ZERO8 8'h00
`define TDP_CTRL_RST 3'h0
`define TDP_PS_DIV1 4'h0
`define TDP_PS_DIV4 4'h3
`define TDP_PS_DIV8 4'h7
`define TDP_PS_DIV16 4'hf
`define TDP_PS_ZERO 4'h0
`define TDP_PS_ONE 4'h1
`endif

/* File: test/tdp_pwm_sink.sv */
// Converter side model that times the master and slave clock pulses
module tdp_pwm_sink (
  input wire logic mclk,
  input wire logic master_pulse,
  input wire logic slave_pulse,
  output logic [15:0] m_per,
  output logic [15:0] m_high,
  output logic [15:0] s_dly
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] t = 16'h0000;
  logic mp = 1'b0;
  logic sp = 1'b0;
  // Only edges are used: the duty is a ceiling, never modulated here
  always @(posedge mclk) begin
    mp <= master_pulse;
    sp <= slave_pulse;
    t <= t + 16'h0001;
    if (master_pulse && !mp) begin
      m_per <= t + 16'h0001;
      t <= 16'h0000;
    end
    if (!master_pulse && mp) m_high <= t + 16'h0001;
    if (slave_pulse && !sp) s_dly <= t + 16'h0001;
  end
endmodule // tdp_pwm_sink

/* File: test/tdp_timer_pwm_asserts.sv */
// Port level checker for the timer pulse block
`include "tdp_consts.vh"
module tdp_timer_pwm_chk #(parameter AW = 4) (
  input wire mclk,
  input wire rstn,
  input wire sleep,
  input wire [AW-1:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  input wire [7:0] rdata,
  input wire master_pulse,
  input wire slave_pulse,
  input wire match_flag
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  sequence s_per_wr_rd;
    wr && addr == `TDP_A_PERIOD ##1 rd && addr == `TDP_A_PERIOD;
  endsequence
  a_rdata_idle: assert property (!rd |=> rdata == 8'h00) else $error("rdata not idle");
  a_unmapped_zero: assert property (rd && addr > `TDP_A_STATUS |=> rdata == 8'h00) else $error("unmapped");
  a_period_back: assert property (s_per_wr_rd |=> rdata == $past(wdata, 2)) else $error("period read");
  a_status_back: assert property (rd && addr == `TDP_A_STATUS |=>
    rdata == {6'h00, $past(slave_pulse), $past(master_pulse)}) else $error("status read");
  a_flag_sticky: assert property (match_flag && !(wr && addr == `TDP_A_FLAGS) |=> match_flag)
    else $error("flag lost");
  a_flag_write: assert property (wr && addr == `TDP_A_FLAGS && wdata[0] |=> match_flag) else $error("flag set");
  a_sleep_master: assert property (sleep |=> $stable(master_pulse)) else $error("master moved");
  a_sleep_slave: assert property (sleep |=> $stable(slave_pulse)) else $error("slave moved");
  a_sleep_flag: assert property (sleep && !match_flag && !wr |=> !match_flag) else $error("flag in sleep");
endmodule // tdp_timer_pwm_chk
bind tdp_timer_pwm tdp_timer_pwm_chk #(.AW(AW)) u_chk (.mclk(mclk), .rstn(rstn), .sleep(sleep), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .master_pulse(master_pulse), .slave_pulse(slave_pulse),
  .match_flag(match_flag));

/* File: test/test_tdp_timer_pwm.sv */
// Self checking bench for the timer pulse block
`include "tdp_consts.vh"
`define CHK(n, e, s) begin comparisons++; if ((e) !== (s)) begin err_total++; \
  $display("BAD %s exp %0h got %0h", n, e, s); end end
module test_tdp_timer_pwm;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk, rstn, sleep, wr, rd, master_pulse, slave_pulse, match_flag;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, d, p, dt, ph, c;
  logic [7:0] prev = 8'h00;
  logic [15:0] m_per, m_high, s_dly;
  logic [31:0] seed = 32'hbc037db1;
  int err_total = 0;
  int comparisons = 0;
  tdp_timer_pwm u_tdp_timer_pwm (.mclk(mclk), .rstn(rstn), .sleep(sleep), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .master_pulse(master_pulse), .slave_pulse(slave_pulse), .match_flag(match_flag));
  tdp_pwm_sink u_tdp_pwm_sink (.mclk(mclk), .master_pulse(master_pulse), .slave_pulse(slave_pulse),
    .m_per(m_per), .m_high(m_high), .s_dly(s_dly));
  always #12.5 mclk = ~mclk;
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [15:0] ps(input logic [1:0] s);
    case (s)
      2'h0: ps = 16'h0001;
      2'h1: ps = 16'h0004;
      2'h2: ps = 16'h0008;
      default: ps = 16'h0010;
    endcase
  endfunction
  // The write strobe stays up until the next task call and rd_r drops rd itself, so none is assigned twice in one step
  task automatic wr_r(input logic [3:0] a, input logic [7:0] v);
    addr <= a; wdata <= v; wr <= 1'b1; rd <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd_r(input logic [3:0] a, output logic [7:0] v);
    addr <= a; rd <= 1'b1; wr <= 1'b0;
    @(posedge mclk);
    rd <= 1'b0;
    @(posedge mclk);
    v = rdata;
  endtask
  task automatic idle(input int n);
    wr <= 1'b0; rd <= 1'b0;
    repeat (n) @(posedge mclk);
  endtask
  task automatic results();
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge mclk);
    err_total++;
    results();
  end
  initial begin
    mclk = 0; rstn = 0; sleep = 0; addr = 0; wdata = 0; wr = 0; rd = 0;
    repeat (20) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    rd_r(`TDP_A_COUNT, d); `CHK("count", 8'h00, d)
    rd_r(`TDP_A_PERIOD, d); `CHK("period", 8'hff, d)
    rd_r(`TDP_A_CTRL, d); `CHK("ctrl", 8'h00, d)
    rd_r(4'hf, d); `CHK("unmapped", 8'h00, d)
    for (int s = 0; s < 4; s++) begin
      p = 8'(8 + xs() % 24); dt = 8'(1 + xs() % p); ph = 8'(1 + xs() % p);
      wr_r(`TDP_A_CTRL, 8'h00); wr_r(`TDP_A_COUNT, 8'h00); wr_r(`TDP_A_PERIOD, p);
      rd_r(`TDP_A_PERIOD, d); `CHK("period", p, d)
      wr_r(`TDP_A_MDUTY, dt); wr_r(`TDP_A_SPHASE, ph); wr_r(`TDP_A_SEND, ph - 8'h01);
      rd_r(`TDP_A_MDUTY_ACT, d); `CHK("duty held", prev, d)
      wr_r(`TDP_A_CTRL, {5'h00, 1'b1, 2'(s)});
      idle(3 * (p + 1) * ps(2'(s)) + 4);
      `CHK("pulse period", 16'((p + 1) * ps(2'(s))), m_per)
      `CHK("master high", 16'(dt * ps(2'(s))), m_high)
      `CHK("slave delay", 16'(ph * ps(2'(s))), s_dly)
      rd_r(`TDP_A_MDUTY_ACT, d); `CHK("duty loaded", dt, d)
      rd_r(`TDP_A_STATUS, d);
      prev = dt;
    end
    wr_r(`TDP_A_CTRL, 8'h00); wr_r(`TDP_A_FLAGS, 8'h00); rd_r(`TDP_A_COUNT, c);
    idle(5); rd_r(`TDP_A_COUNT, d); `CHK("stopped", c, d)
    wr_r(`TDP_A_CTRL, 8'h03); rd_r(`TDP_A_COUNT, d); `CHK("ctrl keeps count", c, d)
    rd_r(`TDP_A_FLAGS, d); `CHK("flag clear", 8'h00, d)
    wr_r(`TDP_A_COUNT, p); wr_r(`TDP_A_CTRL, 8'h04); idle(2);
    `CHK("match", 1'b1, match_flag)
    sleep <= 1'b1;
    wr_r(`TDP_A_FLAGS, 8'h00); idle(6);
    `CHK("sleep flag", 1'b0, match_flag)
    sleep <= 1'b0;
    idle(2);
    wr_r(`TDP_A_FLAGS, 8'h01); idle(1);
    `CHK("flag write", 1'b1, match_flag)
    results();
  end
endmodule // test_tdp_timer_pwm
